/* File: hdl/qsf_pkg.sv */
// Constants shared by the quad-lane serial output framer.
// Assumes a single 20 MHz system clock and an Avalon-MM register slave.
package qsf_pkg;
  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int          LANES        = 4;
  localparam int          BITS         = 8;
  localparam int          AW           = 4;
  localparam logic [7:0]  TEST_BYTE    = 8'hC0;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          LINK_CLK_NS   = 400;
  localparam logic [6:0]  LOCK_PERIODS  = 7'h64;
  // Shortest sample period: one bit slot per system clock
  localparam logic [9:0]  PER_MIN_CYC   = 10'(BITS);
  // Longest sample period before the lock detector gives up
  localparam logic [9:0]  PER_MAX_CYC   = 10'h0FF;
  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [AW-1:0] OFS_STATUS = 4'h0;
  localparam logic [AW-1:0] OFS_MASK   = 4'h4;
  localparam logic [AW-1:0] OFS_STATE  = 4'h8;
  localparam logic [AW-1:0] OFS_CTRL   = 4'hC;
  // ****************************************************************
  // Fields
  // ****************************************************************
  localparam int EV_LOST   = 0;
  localparam int EV_GAINED = 1;
  localparam int EV_RATE   = 2;
  localparam int EV_W      = 3;
  localparam int ST_LOCKED = 0;
  localparam int ST_STBY   = 1;
  localparam int ST_FMT    = 2;
  localparam int ST_TEST   = 3;
  localparam int ST_PER_LO = 8;
  localparam int CT_RELOCK = 0;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [EV_W-1:0] STATUS_RST = 3'h0;
  localparam logic [EV_W-1:0] MASK_RST   = 3'h0;
  // ****************************************************************
  // Lock detector states
  // ****************************************************************
  typedef enum logic [1:0] {
    QSF_ACQ    = 2'b00,
    QSF_LOCKED = 2'b01
  } qsf_lock_t;
endpackage

/* File: hdl/qsf_framer.sv */
// Serial output framer for four 8-bit converter channels.
// Assumes sample clock and strap pins arrive asynchronously; converter
// words come from logic on mclk_i; registers sit on Avalon-MM.
//
// What the link must do
// RQ1 - Format pin high selects twos complement
// RQ2 - Twos complement is offset binary, MSB inverted
// RQ3 - One lane per channel, eight bits per sample
// RQ4 - Sample clock must stay within rate limits
// RQ5 - Bit clock runs at four times sample rate
// RQ6 - Receiver samples data on both bit-clock edges
// RQ7 - Frame clock at sample rate marks bytes
// RQ8 - Lock flag low means locked, data valid
// RQ9 - Lock flag rises at once on unlock
// RQ10 - Unlocked: lanes and bit clock hold still
// RQ11 - Relock needs at least 100 input periods
// RQ12 - First frame edge within 0.5..1.5 periods
// RQ13 - Test pin sends 11000000 on every lane
// RQ14 - Standby puts lane drivers in high impedance
// RQ15 - Bytes go MSB first from frame rise
// RQ16 - Receiver drops bytes while lock flag high
`timescale 1ns/1ns
`default_nettype none
module qsf_framer (
  input  wire logic                            mclk_i,
  input  wire logic                            srst_i,
  input  wire logic                            sample_clk_i,
  input  wire logic                            format_select_pin_i,
  input  wire logic                            test_pattern_select_i,
  input  wire logic                            standby_request_i,
  input  wire logic [qsf_pkg::LANES*qsf_pkg::BITS-1:0] sample_bits_i,
  input  wire logic [qsf_pkg::AW-1:0]          avs_address_i,
  input  wire logic                            avs_read_i,
  input  wire logic                            avs_write_i,
  input  wire logic [31:0]                     avs_writedata_i,
  output logic      [31:0]                     avs_readdata_o,
  output logic                                 avs_waitrequest_o,
  output logic      [qsf_pkg::LANES-1:0]       lane_o,
  output logic                                 lane_oe_n_o,
  output logic                                 bit_clock_out_o,
  output logic                                 frame_clock_out_o,
  output logic                                 lock_n_o,
  output logic                                 irq_o
);
  import qsf_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic       sclk_d_ff;
  // Two flops per asynchronous pin, third for edge detect
  always_ff @(posedge mclk_i) begin
    meta_ff   <= {standby_request_i, test_pattern_select_i,
                  format_select_pin_i, sample_clk_i};
    sync_ff   <= meta_ff;
    sclk_d_ff <= sync_ff[0];
  end
  wire s_rise = sync_ff[0] & ~sclk_d_ff;
  wire fmt_s  = sync_ff[1];
  wire test_s = sync_ff[2];
  wire stby_s = sync_ff[3];

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [EV_W-1:0] status_ff;
  logic [EV_W-1:0] mask_ff;
  logic            relock_ff;
  logic            wait_ff;
  logic [31:0]     rdata_ff;
  logic            irq_ff;
  logic [9:0]      per_ff;
  qsf_lock_t       lock_st_ff;
  wire bus_req  = avs_read_i | avs_write_i;
  wire bus_done = bus_req & ~wait_ff;
  wire wr_fire  = avs_write_i & bus_done;
  wire sel_stat = avs_address_i == OFS_STATUS;
  wire sel_mask = avs_address_i == OFS_MASK;
  wire sel_st   = avs_address_i == OFS_STATE;
  wire sel_ctl  = avs_address_i == OFS_CTRL;
  wire [31:0] state_word = {14'h0000, per_ff, 4'h0, test_s, fmt_s,
                            stby_s, lock_st_ff == QSF_LOCKED};
  // Read mux, unmapped offsets read zero
  wire [31:0] rd_mux =
      sel_stat ? {29'h00000000, status_ff} :
      sel_mask ? {29'h00000000, mask_ff}   :
      sel_st   ? state_word                :
      sel_ctl  ? {31'h00000000, relock_ff} : 32'h00000000;
  // One wait cycle, then answer with data
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h00000000;
    end else begin
      wait_ff  <= ~(bus_req & wait_ff);
      rdata_ff <= (avs_read_i & wait_ff) ? rd_mux : rdata_ff;
    end
  end
  assign avs_waitrequest_o = wait_ff;
  assign avs_readdata_o    = rdata_ff;

  // ****************************************************************
  // Lock detector
  // ****************************************************************
  logic [9:0] cnt_ff;
  logic [6:0] good_cnt_ff;
  logic       lock_n_ff;
  wire [9:0] per_now  = cnt_ff + 10'h001;
  wire [9:0] per_diff = per_now > per_ff ? per_now - per_ff
                                         : per_ff - per_now;
  wire rate_ok   = per_now >= PER_MIN_CYC && per_now <= PER_MAX_CYC;
  wire edge_good = s_rise & rate_ok & per_diff <= 10'h001;
  wire timeout   = cnt_ff >= PER_MAX_CYC;
  wire rate_bad  = (s_rise & ~rate_ok) | timeout;
  wire drop      = stby_s | relock_ff | rate_bad
                 | (s_rise & ~edge_good);
  wire acquire   = lock_st_ff == QSF_ACQ & edge_good & ~drop
                 & good_cnt_ff == LOCK_PERIODS - 7'h01;
  wire unlock_now = lock_st_ff == QSF_LOCKED & drop;
  // Period measurement between sample clock rises
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_ff <= 10'h000;
      per_ff <= 10'h000;
    end else begin
      cnt_ff <= s_rise ? 10'h000 : (timeout ? cnt_ff : per_now);
      per_ff <= s_rise ? per_now : per_ff;
    end
  end
  // Count consistent periods before declaring lock
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      good_cnt_ff <= 7'h00;
    end else if (drop) begin
      good_cnt_ff <= 7'h00;
    end else if (edge_good && good_cnt_ff != LOCK_PERIODS) begin
      good_cnt_ff <= good_cnt_ff + 7'h01; // [RQ11]
    end
  end
  // Lock state and active-low flag
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lock_st_ff <= QSF_ACQ;
      lock_n_ff  <= 1'b1;
    end else begin
      case (lock_st_ff)
        QSF_ACQ: begin
          if (acquire) begin
            lock_st_ff <= QSF_LOCKED; // [RQ11]
            lock_n_ff  <= 1'b0;       // [RQ8]
          end
        end
        QSF_LOCKED: begin
          if (drop) begin
            lock_st_ff <= QSF_ACQ;
            lock_n_ff  <= 1'b1;       // [RQ9] [RQ4]
          end
        end
        default: begin
          lock_st_ff <= QSF_ACQ;
          lock_n_ff  <= 1'b1;
        end
      endcase
    end
  end
  assign lock_n_o = lock_n_ff;

  // ****************************************************************
  // Events, mask and interrupt
  // ****************************************************************
  wire [EV_W-1:0] ev = {rate_bad, acquire, unlock_now};
  wire [EV_W-1:0] w1c = (wr_fire && sel_stat) ?
                        avs_writedata_i[EV_W-1:0] : {EV_W{1'b0}};
  // Sticky status, a new event wins over a clear
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      status_ff <= STATUS_RST;
      mask_ff   <= MASK_RST;
      relock_ff <= 1'b0;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= (status_ff & ~w1c) | ev;
      mask_ff   <= (wr_fire && sel_mask) ?
                   avs_writedata_i[EV_W-1:0] : mask_ff;
      relock_ff <= wr_fire & sel_ctl & avs_writedata_i[CT_RELOCK];
      irq_ff    <= |(status_ff & mask_ff);
    end
  end
  assign irq_o = irq_ff;

  // ****************************************************************
  // Byte coding and serializer
  // ****************************************************************
  logic [BITS-1:0]  shreg_ff [LANES];
  logic [2:0]       bit_ff;
  logic [10:0]      acc_ff;
  logic             bclk_ff;
  logic             fclk_ff;
  logic [LANES-1:0] lane_ff;
  logic             oe_n_ff;
  wire frame_go = s_rise & lock_st_ff == QSF_LOCKED & ~drop; // [RQ7]
  wire locked   = lock_st_ff == QSF_LOCKED & ~drop;
  wire [10:0] acc_nx = acc_ff + 11'(BITS);
  // Fractional divider spreads eight bit slots over one period
  wire bit_tick = locked & ~frame_go & acc_nx >= {1'b0, per_ff}
                & bit_ff != 3'h7;
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      wire [BITS-1:0] raw = sample_bits_i[g*BITS +: BITS];
      // Invert the MSB for twos complement
      wire [BITS-1:0] code = test_s ? TEST_BYTE                // [RQ13]
                           : {raw[BITS-1] ^ fmt_s, raw[BITS-2:0]};
      // Load at frame start, shift MSB first, hold while unlocked
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          shreg_ff[g] <= 8'h00;
          lane_ff[g]  <= 1'b0;
        end else if (frame_go) begin
          shreg_ff[g] <= {code[BITS-2:0], 1'b0};      // [RQ1] [RQ2]
          lane_ff[g]  <= code[BITS-1];                // [RQ15] [RQ3]
        end else if (bit_tick) begin
          shreg_ff[g] <= {shreg_ff[g][BITS-2:0], 1'b0};
          lane_ff[g]  <= shreg_ff[g][BITS-1];         // [RQ10]
        end
      end
    end
  endgenerate
  // Bit slot counter and bit/frame clocks
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      bit_ff  <= 3'h7;
      acc_ff  <= 11'h000;
      bclk_ff <= 1'b0;
      fclk_ff <= 1'b0;
    end else if (frame_go) begin
      bit_ff  <= 3'h0;
      acc_ff  <= 11'h000;
      bclk_ff <= 1'b1;          // [RQ5] [RQ6]
      fclk_ff <= 1'b1;          // [RQ7] [RQ12]
    end else if (bit_tick) begin
      bit_ff  <= bit_ff + 3'h1;
      acc_ff  <= acc_nx - {1'b0, per_ff};
      bclk_ff <= ~bclk_ff;      // [RQ5]
      fclk_ff <= bit_ff < 3'h3;
    end else if (locked) begin
      acc_ff  <= acc_nx;
    end else if (acquire) begin
      // Park both clocks low so the first frame shows real edges
      bclk_ff <= 1'b0;          // [RQ12]
      fclk_ff <= 1'b0;          // [RQ12] [RQ15]
    end
  end
  // Drivers released in standby
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      oe_n_ff <= 1'b1;
    end else begin
      oe_n_ff <= stby_s;        // [RQ14]
    end
  end
  assign lane_o            = lane_ff;
  assign lane_oe_n_o       = oe_n_ff;
  assign bit_clock_out_o   = bclk_ff;
  assign frame_clock_out_o = fclk_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // First-frame window helpers: cycles since lock fell, frame seen
  logic [10:0] since_lock_ff;
  logic        first_seen_ff;
  wire  [11:0] since_x2 = {since_lock_ff, 1'b0};
  wire  [11:0] per_x3   = {2'b00, per_ff} + {1'b0, per_ff, 1'b0};
  always_ff @(posedge mclk_i) begin
    if (srst_i || lock_n_ff) begin
      since_lock_ff <= 11'h000;
      first_seen_ff <= 1'b0;
    end else begin
      since_lock_ff <= since_lock_ff + 11'h001;
      first_seen_ff <= first_seen_ff | fclk_ff;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  format_code_a: assert property ( // [RQ1] [RQ2]
    frame_go && !test_s |=> lane_ff[0] ==
      ($past(sample_bits_i[BITS-1]) ^ $past(fmt_s)))
    else $error("lane 0 first bit not coded per format pin");
  test_byte_a: assert property ( // [RQ13]
    frame_go && test_s |=> lane_ff == 4'hF
      && shreg_ff[1] == {TEST_BYTE[BITS-2:0], 1'b0})
    else $error("test pattern not loaded");
  valid_lock_a: assert property ( // [RQ8]
    frame_go |-> !lock_n_ff ##1 fclk_ff)
    else $error("frame started while lock flag high");
  fast_unlock_a: assert property ( // [RQ9]
    unlock_now |=> lock_n_o && $stable(frame_clock_out_o)
      && $stable(bit_clock_out_o))
    else $error("lock flag did not rise at once");
  hold_static_a: assert property ( // [RQ10]
    lock_n_ff && $past(lock_n_ff) |-> $stable(bclk_ff)
      && $stable(lane_ff) && $stable(fclk_ff))
    else $error("lanes or bit clock moved while unlocked");
  relock_count_a: assert property ( // [RQ11]
    $fell(lock_n_ff) |-> $past(good_cnt_ff) == 7'h63)
    else $error("lock regained before 100 periods");
  first_frame_a: assert property ( // [RQ12]
    $fell(lock_n_ff) |-> ##[1:260] ($rose(fclk_ff) || lock_n_ff))
    else $error("no frame edge after lock");
  standby_hiz_a: assert property ( // [RQ14]
    stby_s |=> lane_oe_n_o ##1 lock_n_o)
    else $error("standby did not release drivers");
  rate_fault_a: assert property ( // [RQ4]
    rate_bad |=> lock_n_o && status_ff[EV_RATE])
    else $error("rate fault not reported");
  irq_level_a: assert property (
    |(status_ff & mask_ff) |=> irq_o)
    else $error("interrupt missing");

  first_early_a: assert property ( // [RQ12]
    $rose(fclk_ff) && !first_seen_ff |-> since_x2 >= {2'b00, per_ff})
    else $error("first frame edge came too early after lock");

  first_late_a: assert property ( // [RQ12]
    !lock_n_ff && !first_seen_ff |-> since_x2 < per_x3)
    else $error("first frame edge came too late after lock");

  eight_bits_a: assert property ( // [RQ3]
    frame_go && first_seen_ff |-> bit_ff == 3'h7)
    else $error("byte cut short before next frame");

  bit_clock_a: assert property ( // [RQ5]
    bit_tick |=> bclk_ff != $past(bclk_ff))
    else $error("bit clock missed a slot edge");

  msb_first_a: assert property ( // [RQ15]
    bit_tick |=> lane_ff[2] == $past(shreg_ff[2][BITS-1]))
    else $error("lane bit not taken from shift register top");
endmodule
`default_nettype wire

/* File: test/qsf_rx_model.sv */
// Receiver model: deserialises the four lanes against the bit clock.
// Assumes the framer's outputs change only just after mclk_i edges.
`timescale 1ns/1ns
`default_nettype none
module qsf_rx_model (
  input  wire logic        mclk_i,
  input  wire logic [3:0]  lane_i,
  input  wire logic        bclk_i,
  input  wire logic        fclk_i,
  input  wire logic        lock_n_i,
  output logic             got_o,
  output logic [31:0]      word_o
);
  logic        bclk_ff = 1'b0;
  logic        fclk_ff = 1'b0;
  logic [3:0]  cnt_ff  = 4'h0;
  logic [31:0] sh_ff   = 32'h0;
  logic [31:0] nxt_sh;
  logic [3:0]  nxt_cnt;
  logic        edge_w;
  // One bit per lane per bit-clock edge, MSB first
  assign edge_w  = (bclk_i != bclk_ff);
  assign nxt_cnt = (fclk_i && !fclk_ff) ? 4'h1 : cnt_ff + 4'h1;
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      nxt_sh[8*g +: 8] = {sh_ff[8*g +: 7], lane_i[g]};
    end
  end
  // Byte counter restarts at frame rise; bytes dropped while unlocked
  always_ff @(posedge mclk_i) begin
    bclk_ff <= bclk_i;
    fclk_ff <= fclk_i;
    got_o   <= 1'b0;
    if (lock_n_i) begin
      cnt_ff <= 4'h0;
    end else if (edge_w && (cnt_ff != 4'h0 || (fclk_i && !fclk_ff))) begin
      sh_ff  <= nxt_sh;
      cnt_ff <= (nxt_cnt == 4'h8) ? 4'h0 : nxt_cnt;
      got_o  <= (nxt_cnt == 4'h8);
      word_o <= nxt_sh;
    end
  end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the quad-lane serial output framer.
// Assumes qsf_pkg and qsf_framer compiled first; no checker file.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import qsf_pkg::*;
  logic        mclk_i = 0, srst_i = 1, sclk = 0, fmt = 0, tst = 0;
  logic        stby = 0, rd = 0, wr = 0, run = 0;
  logic [31:0] bits = 0, wdata = 0, rdata, word, rd_word;
  logic [3:0]  addr = 0, lane;
  logic        waitreq, oe_n, bclk, fclk, lock_n, irq, got;
  logic [5:0]  snap;
  logic [31:0] exp_q[$];
  int          err_count = 0, n_compared = 0, seed = 94, cyc = 0, n;
  // ****************************************************************
  // Clocks, design and receiver
  // ****************************************************************
  always #25 mclk_i = ~mclk_i;
  always #200 if (run) sclk = ~sclk;
  qsf_framer uut (.mclk_i(mclk_i), .srst_i(srst_i), .sample_clk_i(sclk),
    .format_select_pin_i(fmt), .test_pattern_select_i(tst),
    .standby_request_i(stby), .sample_bits_i(bits), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .lane_o(lane),
    .lane_oe_n_o(oe_n), .bit_clock_out_o(bclk), .frame_clock_out_o(fclk),
    .lock_n_o(lock_n), .irq_o(irq));
  qsf_rx_model rx (.mclk_i(mclk_i), .lane_i(lane), .bclk_i(bclk),
    .fclk_i(fclk), .lock_n_i(lock_n), .got_o(got), .word_o(word));
  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Avalon-MM transfer held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge mclk_i);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    do begin
      @(posedge mclk_i);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    if (k >= 50) err_count++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  function automatic logic pick(input int s);
    return (s == 0) ? lock_n : (s == 1) ? fclk : irq;
  endfunction
  task automatic wait_for(input int s, input logic v, output int k);
    k = 0;
    while (pick(s) !== v && k < 3000) begin
      @(posedge mclk_i);
      k++;
    end
    if (k >= 3000) err_count++;
  endtask
  function automatic logic [31:0] lane_word(input logic [31:0] b,
                                            input logic f, t);
    return t ? {4{TEST_BYTE}} : (b ^ (f ? 32'h80808080 : 32'h0));
  endfunction
  // Compare each received lane word with the oldest note
  always @(posedge mclk_i) begin
    cyc++;
    if (got === 1'b1 && exp_q.size() > 0) begin
      chk("lane word", word, exp_q.pop_front());
    end
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge mclk_i);
    srst_i <= 1'b0;
    run = 1'b1;
    wait_for(0, 1'b0, n);
    chk("relock long", 32'(n >= 792), 32'h1);
    wait_for(1, 1'b1, n);
    chk("first frame", 32'(n >= 4 && n < 12), 32'h1);
    chk("drivers on", 32'(oe_n), 32'h0);
    $display("Test 1 done");
    for (int k = 0; k < 4; k++) begin
      bits <= $random(seed);
      fmt  <= k[0];
      tst  <= (k == 3);
      repeat (3) begin
        wait_for(1, 1'b0, n);
        wait_for(1, 1'b1, n);
      end
      for (int j = 0; j < 3; j++) exp_q.push_back(lane_word(bits, fmt, tst));
      n = 0;
      while (exp_q.size() > 0 && n < 400) begin
        @(posedge mclk_i);
        n++;
      end
      chk("notes left", exp_q.size(), 32'h0);
    end
    $display("Test 2 done");
    bus(1'b1, OFS_MASK, 32'h1, rd_word);
    run = 1'b0;
    wait_for(0, 1'b1, n);
    snap = {bclk, fclk, lane};
    chk("unlock quick", 32'(n < 300), 32'h1);
    repeat (60) @(posedge mclk_i);
    chk("frozen", 32'({bclk, fclk, lane}), 32'(snap));
    chk("irq lost", 32'(irq), 32'h1);
    bus(1'b0, OFS_STATUS, 32'h0, rd_word);
    chk("lost bit", rd_word & 32'h1, 32'h1);
    bus(1'b1, OFS_STATUS, 32'h7, rd_word);
    bus(1'b0, 4'h6, 32'h0, rd_word);
    chk("unmapped", rd_word, 32'h0);
    chk("irq clear", 32'(irq), 32'h0);
    run = 1'b1;
    wait_for(0, 1'b0, n);
    bus(1'b0, OFS_STATUS, 32'h0, rd_word);
    chk("gained bit", rd_word & 32'h2, 32'h2);
    chk("irq masked", 32'(irq), 32'h0);
    bus(1'b1, OFS_MASK, 32'h2, rd_word);
    wait_for(2, 1'b1, n);
    chk("irq unmask", 32'(n < 4), 32'h1);
    bus(1'b1, OFS_STATUS, 32'h7, rd_word);
    $display("Test 3 done");
    stby <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk("standby hiz", 32'({oe_n, lock_n}), 32'h3);
    bus(1'b0, OFS_STATE, 32'h0, rd_word);
    chk("state stby", rd_word, (32'(LINK_CLK_NS / CLK_PERIOD_NS) << ST_PER_LO)
        | (32'h1 << ST_STBY) | (32'h1 << ST_FMT) | (32'h1 << ST_TEST));
    stby <= 1'b0;
    wait_for(0, 1'b0, n);
    chk("wake", 32'({oe_n, lock_n}), 32'h0);
    // Forced relock, then the first byte after it must be whole
    bus(1'b1, OFS_CTRL, 32'h1, rd_word);
    wait_for(0, 1'b1, n);
    chk("relock drop", 32'(n < 4), 32'h1);
    wait_for(0, 1'b0, n);
    chk("relock again", 32'(n >= 792), 32'h1);
    exp_q.push_back(lane_word(bits, fmt, tst));
    wait_for(1, 1'b1, n);
    chk("relock frame", 32'(n >= 4 && n < 12), 32'h1);
    repeat (12) @(posedge mclk_i);
    chk("first byte", exp_q.size(), 32'h0);
    $display("Test 4 done");
    give_verdict();
  end
endmodule
`default_nettype wire
